/* File: verilog/opdec_table.sv */
// Combinational opcode table: one byte in, one decoded word out.
`timescale 1ns/1ps
module opdec_table (
    input  wire logic [7:0]        opcode_i,
    output opdec_pkg::decode_t     dec_o
);

    wire       is_ptr_y = opcode_i[opdec_pkg::PTR_SEL_BIT];
    wire [7:0] short_ad = opdec_pkg::SHORT_BASE | {6'h00, opcode_i[1:0]};
    wire [7:0] ptr_ad   = is_ptr_y ? opdec_pkg::Y_POINTER_ADDR : opdec_pkg::X_POINTER_ADDR;
    wire [1:0] alu_sel  = opcode_i[1:0] - 2'h2;
    wire       alu_ind  = (opcode_i[3:0] >= 4'h2) && (opcode_i[3:0] <= 4'h5)
                          && (opcode_i[7:5] == 3'h7);
    wire       alu_imm  = (opcode_i >= opdec_pkg::ALU_IMM_LO) && (opcode_i <= opdec_pkg::ALU_IMM_HI);
    wire       alu_dir  = (opcode_i >= opdec_pkg::ALU_DIR_LO) && (opcode_i <= opdec_pkg::ALU_DIR_HI);
    wire       ind_form = (opcode_i[7:5] == 3'h7) && (opcode_i[3] == 1'b0);

    always_comb begin
        opdec_pkg::op_kind_t alu_kind;
        alu_kind = opdec_pkg::OP_ADD;
        case (alu_sel)
            2'h0: alu_kind = opdec_pkg::OP_ADD;
            2'h1: alu_kind = opdec_pkg::OP_SUB;
            2'h2: alu_kind = opdec_pkg::OP_COMPARE;
            default: alu_kind = opdec_pkg::OP_AND;
        endcase
        dec_o            = '0;
        dec_o.op_class   = opdec_pkg::CLS_NONE;
        dec_o.mode       = opdec_pkg::AM_NONE;
        dec_o.kind       = opdec_pkg::OP_NONE;
        dec_o.length     = opdec_pkg::LEN_ONE;
        dec_o.cycles     = opdec_pkg::CYC_NONE;
        dec_o.target_hi  = opcode_i[3:0];
        if (ind_form) begin
            dec_o.data_addr  = ptr_ad;
            dec_o.addr_fixed = 1'b1;
        end
        if (opcode_i == opdec_pkg::LOAD_IND_X || opcode_i == opdec_pkg::LOAD_IND_Y ||
            opcode_i == opdec_pkg::LOAD_IMM || opcode_i == opdec_pkg::LOAD_DIR ||
            opcode_i[7:2] == opdec_pkg::LOAD_SHORT) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.kind     = opdec_pkg::OP_LOAD_ACC;
            dec_o.src_b    = (opcode_i == opdec_pkg::LOAD_IMM) ? opdec_pkg::SRC_PROG
                                                               : opdec_pkg::SRC_MEMORY;
            dec_o.dst      = opdec_pkg::DST_ACC;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i == opdec_pkg::STORE_IND_X || opcode_i == opdec_pkg::STORE_IND_Y ||
                 opcode_i == opdec_pkg::STORE_DIR || opcode_i[7:2] == opdec_pkg::STORE_SHORT) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.kind     = opdec_pkg::OP_STORE_ACC;
            dec_o.src_a    = opdec_pkg::SRC_ACC;
            dec_o.dst      = opdec_pkg::DST_MEMORY;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (alu_ind || alu_imm || alu_dir) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.kind     = alu_kind;
            dec_o.src_a    = opdec_pkg::SRC_ACC;
            dec_o.src_b    = alu_imm ? opdec_pkg::SRC_PROG : opdec_pkg::SRC_MEMORY;
            dec_o.dst      = (alu_kind == opdec_pkg::OP_COMPARE) ? opdec_pkg::DST_NONE
                                                                 : opdec_pkg::DST_ACC;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i[7:4] == opdec_pkg::CALL_NIBBLE ||
                 opcode_i[7:4] == opdec_pkg::JUMP_NIBBLE) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.mode     = opdec_pkg::AM_EXTENDED;
            dec_o.kind     = opcode_i[4] ? opdec_pkg::OP_JUMP : opdec_pkg::OP_CALL;
            dec_o.dst      = opdec_pkg::DST_PC;
            dec_o.length   = opdec_pkg::LEN_TWO;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i == opdec_pkg::MOVE_IMM) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.mode     = opdec_pkg::AM_IMMEDIATE;
            dec_o.kind     = opdec_pkg::OP_MOVE_IMM;
            dec_o.src_b    = opdec_pkg::SRC_PROG;
            dec_o.dst      = opdec_pkg::DST_MEMORY;
            dec_o.length   = opdec_pkg::LEN_THREE;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i == opdec_pkg::COMPL_ACC || opcode_i == opdec_pkg::ROTATE_ACC) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_REGMEM;
            dec_o.mode     = opdec_pkg::AM_INHERENT;
            dec_o.kind     = opcode_i[0] ? opdec_pkg::OP_ROTATE_ACC : opdec_pkg::OP_COMPL_ACC;
            dec_o.src_a    = opdec_pkg::SRC_ACC;
            dec_o.dst      = opdec_pkg::DST_ACC;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i == opdec_pkg::INC_IND_X || opcode_i == opdec_pkg::INC_IND_Y ||
                 opcode_i == opdec_pkg::INC_DIR || opcode_i[7:2] == opdec_pkg::INC_SHORT) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_RMW;
            dec_o.kind     = opdec_pkg::OP_STEP_UP;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i == opdec_pkg::DEC_IND_X || opcode_i == opdec_pkg::DEC_IND_Y ||
                 opcode_i == opdec_pkg::DEC_DIR || opcode_i[7:2] == opdec_pkg::DEC_SHORT) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_RMW;
            dec_o.kind     = opdec_pkg::OP_STEP_DOWN;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i[7:3] == opdec_pkg::BITSET_BASE ||
                 opcode_i[7:3] == opdec_pkg::BITCLR_BASE) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_BITMAN;
            dec_o.mode     = opdec_pkg::AM_BITSETCLR;
            dec_o.kind     = opcode_i[3] ? opdec_pkg::OP_BIT_SET : opdec_pkg::OP_BIT_CLEAR;
            dec_o.length   = opdec_pkg::LEN_TWO;
            dec_o.cycles   = opdec_pkg::CYC_FOUR;
        end
        else if (opcode_i[7:3] == opdec_pkg::BRSET_BASE ||
                 opcode_i[7:3] == opdec_pkg::BRCLR_BASE) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_BITMAN;
            dec_o.mode     = opdec_pkg::AM_BITTEST;
            dec_o.kind     = opdec_pkg::OP_BIT_TEST;
            dec_o.length   = opdec_pkg::LEN_THREE;
            dec_o.cycles   = opdec_pkg::CYC_FIVE;
        end
        else if (opcode_i[7] == 1'b0) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_BRANCH;
            dec_o.mode     = opdec_pkg::AM_RELATIVE;
            dec_o.kind     = opdec_pkg::OP_BRANCH;
            dec_o.dst      = opdec_pkg::DST_PC;
            dec_o.cycles   = opdec_pkg::CYC_TWO;
        end
        else if (opcode_i == opdec_pkg::RETURN_SUB || opcode_i == opdec_pkg::RETURN_INT) begin
            dec_o.valid    = 1'b1;
            dec_o.op_class = opdec_pkg::CLS_CONTROL;
            dec_o.mode     = opdec_pkg::AM_INHERENT;
            dec_o.kind     = opcode_i[0] ? opdec_pkg::OP_RETURN : opdec_pkg::OP_RETURN_INT;
            dec_o.dst      = opdec_pkg::DST_PC;
            dec_o.cycles   = opdec_pkg::CYC_TWO;
        end
        // Memory-operand forms share their mode and address from the opcode shape.
        if (dec_o.valid && dec_o.mode == opdec_pkg::AM_NONE) begin
            if (ind_form) begin
                dec_o.mode = opdec_pkg::AM_INDIRECT;
            end else if (opcode_i[7:6] == 2'h2) begin
                dec_o.mode       = opdec_pkg::AM_SHORT;
                dec_o.data_addr  = short_ad;
                dec_o.addr_fixed = 1'b1;
            end else if (opcode_i[4]) begin
                dec_o.mode   = opdec_pkg::AM_DIRECT;
                dec_o.length = opdec_pkg::LEN_TWO;
            end else begin
                dec_o.mode   = opdec_pkg::AM_IMMEDIATE;
                dec_o.length = opdec_pkg::LEN_TWO;
            end
        end
        // step and bit set/clear ops are RMW
        if (dec_o.op_class == opdec_pkg::CLS_RMW ||
            dec_o.kind == opdec_pkg::OP_BIT_SET || dec_o.kind == opdec_pkg::OP_BIT_CLEAR) begin
            dec_o.rmw   = 1'b1;
            dec_o.src_b = opdec_pkg::SRC_MEMORY;
            dec_o.dst   = opdec_pkg::DST_MEMORY;
        end
    end

endmodule

/* File: verilog/opdec_pkg.sv */
// Package of opcode decoder types, encodings and constants.
package opdec_pkg;

    // Operation classes.
    typedef enum logic [2:0] {
        CLS_REGMEM  = 3'h0,
        CLS_RMW     = 3'h1,
        CLS_BRANCH  = 3'h2,
        CLS_BITMAN  = 3'h3,
        CLS_CONTROL = 3'h4,
        CLS_NONE    = 3'h7
    } op_class_t;

    // Addressing modes, nine documented plus none.
    typedef enum logic [3:0] {
        AM_IMMEDIATE = 4'h0,
        AM_DIRECT    = 4'h1,
        AM_SHORT     = 4'h2,
        AM_EXTENDED  = 4'h3,
        AM_RELATIVE  = 4'h4,
        AM_BITSETCLR = 4'h5,
        AM_BITTEST   = 4'h6,
        AM_INDIRECT  = 4'h7,
        AM_INHERENT  = 4'h8,
        AM_NONE      = 4'hF
    } addr_mode_t;

    // Operations.
    typedef enum logic [4:0] {
        OP_NONE        = 5'h00,
        OP_LOAD_ACC    = 5'h01,
        OP_STORE_ACC   = 5'h02,
        OP_ADD         = 5'h03,
        OP_SUB         = 5'h04,
        OP_COMPARE     = 5'h05,
        OP_AND         = 5'h06,
        OP_CALL        = 5'h07,
        OP_JUMP        = 5'h08,
        OP_MOVE_IMM    = 5'h09,
        OP_COMPL_ACC   = 5'h0A,
        OP_ROTATE_ACC  = 5'h0B,
        OP_STEP_UP     = 5'h0C,
        OP_STEP_DOWN   = 5'h0D,
        OP_BRANCH      = 5'h0E,
        OP_BIT_SET     = 5'h0F,
        OP_BIT_CLEAR   = 5'h10,
        OP_BIT_TEST    = 5'h11,
        OP_RETURN      = 5'h12,
        OP_RETURN_INT  = 5'h13
    } op_kind_t;

    // Operand sources.
    typedef enum logic [1:0] {
        SRC_NONE   = 2'h0,
        SRC_ACC    = 2'h1,
        SRC_MEMORY = 2'h2,
        SRC_PROG   = 2'h3
    } op_src_t;

    // Destinations.
    typedef enum logic [1:0] {
        DST_NONE   = 2'h0,
        DST_ACC    = 2'h1,
        DST_MEMORY = 2'h2,
        DST_PC     = 2'h3
    } op_dst_t;

    // Decoded instruction word.
    typedef struct packed {
        logic       valid;
        op_class_t  op_class;
        addr_mode_t mode;
        op_kind_t   kind;
        op_src_t    src_a;
        op_src_t    src_b;
        op_dst_t    dst;
        logic       rmw;
        logic       addr_fixed;
        logic [7:0] data_addr;
        logic [3:0] target_hi;
        logic [1:0] length;
        logic [2:0] cycles;
    } decode_t;

    // Data-space locations.
    localparam logic [7:0] X_POINTER_ADDR = 8'h80;
    localparam logic [7:0] Y_POINTER_ADDR = 8'h81;
    localparam logic [7:0] ACC_ADDR       = 8'hFF;
    localparam logic [7:0] SHORT_BASE     = 8'h80;
    localparam int         PTR_SEL_BIT    = 4;

    // Opcode encodings.
    localparam logic [7:0] LOAD_IND_X   = 8'hE0;
    localparam logic [7:0] LOAD_IND_Y   = 8'hF0;
    localparam logic [7:0] LOAD_IMM     = 8'hE8;
    localparam logic [7:0] LOAD_DIR     = 8'hF8;
    localparam logic [5:0] LOAD_SHORT   = 6'h2B;
    localparam logic [7:0] STORE_IND_X  = 8'hE1;
    localparam logic [7:0] STORE_IND_Y  = 8'hF1;
    localparam logic [7:0] STORE_DIR    = 8'hF9;
    localparam logic [5:0] STORE_SHORT  = 6'h2F;
    localparam logic [3:0] CALL_NIBBLE  = 4'h8;
    localparam logic [3:0] JUMP_NIBBLE  = 4'h9;
    localparam logic [7:0] ALU_IND_X_LO = 8'hE2;
    localparam logic [7:0] ALU_IND_X_HI = 8'hE5;
    localparam logic [7:0] ALU_IMM_LO   = 8'hEA;
    localparam logic [7:0] ALU_IMM_HI   = 8'hED;
    localparam logic [7:0] ALU_DIR_LO   = 8'hFA;
    localparam logic [7:0] ALU_DIR_HI   = 8'hFD;
    localparam logic [7:0] MOVE_IMM     = 8'hB0;
    localparam logic [7:0] COMPL_ACC    = 8'hB4;
    localparam logic [7:0] ROTATE_ACC   = 8'hB5;
    localparam logic [7:0] INC_IND_X    = 8'hE6;
    localparam logic [7:0] INC_IND_Y    = 8'hF6;
    localparam logic [7:0] INC_DIR      = 8'hFE;
    localparam logic [5:0] INC_SHORT    = 6'h2A;
    localparam logic [7:0] DEC_IND_X    = 8'hE7;
    localparam logic [7:0] DEC_IND_Y    = 8'hF7;
    localparam logic [7:0] DEC_DIR      = 8'hFF;
    localparam logic [5:0] DEC_SHORT    = 6'h2E;
    localparam logic [7:0] RETURN_SUB   = 8'hB3;
    localparam logic [7:0] RETURN_INT   = 8'hB2;
    localparam logic [4:0] BITSET_BASE  = 5'h1B;
    localparam logic [4:0] BITCLR_BASE  = 5'h1A;
    localparam logic [4:0] BRSET_BASE   = 5'h19;
    localparam logic [4:0] BRCLR_BASE   = 5'h18;

    // Instruction lengths and cycle counts.
    localparam logic [1:0] LEN_ONE    = 2'h1;
    localparam logic [1:0] LEN_TWO    = 2'h2;
    localparam logic [1:0] LEN_THREE  = 2'h3;
    localparam logic [2:0] CYC_FOUR   = 3'h4;
    localparam logic [2:0] CYC_TWO    = 3'h2;
    localparam logic [2:0] CYC_FIVE   = 3'h5;
    localparam logic [2:0] CYC_NONE   = 3'h1;

endpackage

/* File: verilog/mcu_opcode_decoder.sv */
// Registered opcode decoder for the 8-bit core, with its decode table.
`timescale 1ns/1ps
module mcu_opcode_decoder (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic                fetch_valid_i,
    input  wire logic [7:0]          opcode_i,
    output opdec_pkg::decode_t       decode_o,
    output logic                     decode_valid_o,
    output logic                     read_phase_o,
    output logic                     write_phase_o,
    output logic                     shift_left_hint_o
);

    opdec_pkg::decode_t table_dec;
    opdec_pkg::decode_t dec_q;
    logic               dvalid_q;
    logic [1:0]         phase_q;
    logic [1:0]         phase_d;

    opdec_table u_table (
        .opcode_i (opcode_i),
        .dec_o    (table_dec)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dec_q    <= '0;
            dvalid_q <= 1'b0;
        end else begin
            dvalid_q <= fetch_valid_i;
            if (fetch_valid_i) begin
                dec_q <= table_dec;
            end
        end
    end

    assign phase_d = (fetch_valid_i && table_dec.rmw) ? 2'h1
                   : (phase_q == 2'h1) ? 2'h2 : 2'h0;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign decode_o       = dec_q;
    assign decode_valid_o = dvalid_q;
    assign read_phase_o   = (phase_q == 2'h1);
    assign write_phase_o  = (phase_q == 2'h2);
    assign shift_left_hint_o = dvalid_q && (dec_q.kind == opdec_pkg::OP_ADD)
                               && (dec_q.mode == opdec_pkg::AM_DIRECT);

    // Assertions.
    // add and and: accumulator plus a memory or program operand
    a_regmem_operands: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dvalid_q && dec_q.op_class == opdec_pkg::CLS_REGMEM &&
        (dec_q.kind == opdec_pkg::OP_ADD || dec_q.kind == opdec_pkg::OP_AND)
        |-> dec_q.src_a == opdec_pkg::SRC_ACC && dec_q.src_b != opdec_pkg::SRC_NONE)
        else $error("register/memory op lacks operands");

    a_call_no_reg: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dvalid_q && (dec_q.kind == opdec_pkg::OP_CALL || dec_q.kind == opdec_pkg::OP_JUMP)
        |-> dec_q.src_a == opdec_pkg::SRC_NONE && dec_q.dst == opdec_pkg::DST_PC)
        else $error("call or jump uses a register");

    sequence s_rmw_fetch;
        fetch_valid_i && table_dec.rmw;
    endsequence

    a_rmw_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_rmw_fetch |=> read_phase_o)
        else $error("read phase missing after rmw fetch");

    // A fresh rmw fetch restarts the read phase, so the write is checked only when none follows.
    a_rmw_phases: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (s_rmw_fetch ##1 !(fetch_valid_i && table_dec.rmw)) |-> read_phase_o ##1 write_phase_o)
        else $error("read-modify-write phases out of order");

    a_step_is_rmw: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dvalid_q && (dec_q.kind == opdec_pkg::OP_STEP_UP || dec_q.kind == opdec_pkg::OP_BIT_SET)
        |-> dec_q.rmw)
        else $error("step or bit op not read-modify-write");

    a_load_short: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hAE |=>
        dec_q.kind == opdec_pkg::OP_LOAD_ACC && dec_q.data_addr == 8'h82)
        else $error("short load address wrong");

    a_store_short: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hBD |=>
        dec_q.kind == opdec_pkg::OP_STORE_ACC && dec_q.data_addr == 8'h81)
        else $error("short store address wrong");

    a_jump_target: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i[7:4] == 4'h9 |=>
        dec_q.kind == opdec_pkg::OP_JUMP && dec_q.target_hi == $past(opcode_i[3:0])
        && dec_q.length == 2'h2)
        else $error("jump target nibble wrong");

    a_compare_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hEC |=>
        dec_q.kind == opdec_pkg::OP_COMPARE && dec_q.dst == opdec_pkg::DST_NONE)
        else $error("compare writes accumulator");

    a_move_three: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hB0 |=>
        dec_q.kind == opdec_pkg::OP_MOVE_IMM && dec_q.length == 2'h3)
        else $error("move immediate length wrong");

    a_step_down_y: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hB9 |=>
        dec_q.kind == opdec_pkg::OP_STEP_DOWN && dec_q.data_addr == 8'h81)
        else $error("step down Y address wrong");

    a_indirect_ptr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hF7 |=>
        dec_q.mode == opdec_pkg::AM_INDIRECT && dec_q.data_addr == 8'h81)
        else $error("indirect pointer select wrong");

    a_undef_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dvalid_q && !dec_q.valid |->
        dec_q.dst == opdec_pkg::DST_NONE && dec_q.length == 2'h1 && !dec_q.rmw)
        else $error("undefined opcode has side effect");

    a_count_cls: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dvalid_q && dec_q.valid |-> dec_q.op_class != opdec_pkg::CLS_NONE)
        else $error("valid opcode without class");

    a_inherent_acc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hB5 |=> dec_q.kind == opdec_pkg::OP_ROTATE_ACC)
        else $error("rotate opcode wrong");

    a_step_up_x: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hA8 |=>
        dec_q.kind == opdec_pkg::OP_STEP_UP && dec_q.data_addr == 8'h80)
        else $error("step up X address wrong");

    a_shift_hint: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fetch_valid_i && opcode_i == 8'hFA |=> shift_left_hint_o)
        else $error("direct add hint missing");

endmodule

/* File: verif/fetch_model.sv */
// Behavioural fetch unit that hands opcode bytes to the decoder.
`timescale 1ns/1ps
module fetch_model (
    input  wire logic       sys_clk_i,
    input  wire logic       req_i,
    input  wire logic [7:0] byte_i,
    output logic            fetch_valid_o,
    output logic [7:0]      opcode_o
);
    initial begin
        fetch_valid_o = 1'b0;
        opcode_o      = 8'hA5;
    end
    // Outside a fetch the lane is not held, so it toggles to expose any stale capture.
    always @(posedge sys_clk_i) begin
        fetch_valid_o <= #1 req_i;
        opcode_o      <= #1 (req_i ? byte_i : ~opcode_o);
    end
endmodule

/* File: verif/mcu_opcode_decoder_test.sv */
// Self-checking bench for the registered opcode decoder.
`timescale 1ns/1ps
module mcu_opcode_decoder_test;
    localparam opdec_pkg::op_kind_t LD = opdec_pkg::OP_LOAD_ACC, ST = opdec_pkg::OP_STORE_ACC,
        AD = opdec_pkg::OP_ADD, SB = opdec_pkg::OP_SUB, CP = opdec_pkg::OP_COMPARE,
        AN = opdec_pkg::OP_AND, CO = opdec_pkg::OP_COMPL_ACC, RO = opdec_pkg::OP_ROTATE_ACC,
        UP = opdec_pkg::OP_STEP_UP, DN = opdec_pkg::OP_STEP_DOWN;
    localparam opdec_pkg::addr_mode_t IX = opdec_pkg::AM_INDIRECT, IM = opdec_pkg::AM_IMMEDIATE,
        DI = opdec_pkg::AM_DIRECT, SH = opdec_pkg::AM_SHORT, IH = opdec_pkg::AM_INHERENT;
    typedef struct packed {
        logic [7:0]             op;
        opdec_pkg::op_kind_t    k;
        opdec_pkg::addr_mode_t  m;
        logic [1:0]             len;
        logic                   rmw;
        logic [7:0]             ad;
    } row_t;
    // A zero address column means no fixed address is checked; only the direct rows take theirs from a following byte.
    row_t rows [20] = '{
        '{8'hE0, LD, IX, 2'h1, 1'b0, 8'h80}, '{8'hF0, LD, IX, 2'h1, 1'b0, 8'h81},
        '{8'hE8, LD, IM, 2'h2, 1'b0, 8'h00}, '{8'hF8, LD, DI, 2'h2, 1'b0, 8'h00},
        '{8'hAE, LD, SH, 2'h1, 1'b0, 8'h82}, '{8'hE1, ST, IX, 2'h1, 1'b0, 8'h80},
        '{8'hF9, ST, DI, 2'h2, 1'b0, 8'h00}, '{8'hBD, ST, SH, 2'h1, 1'b0, 8'h81},
        '{8'hE2, AD, IX, 2'h1, 1'b0, 8'h80}, '{8'hF3, SB, IX, 2'h1, 1'b0, 8'h81},
        '{8'hEC, CP, IM, 2'h2, 1'b0, 8'h00}, '{8'hFD, AN, DI, 2'h2, 1'b0, 8'h00},
        '{8'hB4, CO, IH, 2'h1, 1'b0, 8'h00}, '{8'hB5, RO, IH, 2'h1, 1'b0, 8'h00},
        '{8'hE6, UP, IX, 2'h1, 1'b1, 8'h80}, '{8'hFE, UP, DI, 2'h2, 1'b1, 8'h00},
        '{8'hA8, UP, SH, 2'h1, 1'b1, 8'h80}, '{8'hF7, DN, IX, 2'h1, 1'b1, 8'h81},
        '{8'hB9, DN, SH, 2'h1, 1'b1, 8'h81}, '{8'hFF, DN, DI, 2'h2, 1'b1, 8'h00}};
    logic               sys_clk;
    logic               rst;
    logic               req;
    logic [7:0]         byte_v;
    logic               fetch_valid;
    logic [7:0]         opcode;
    opdec_pkg::decode_t dec;
    logic               dec_valid;
    logic               rd_ph;
    logic               wr_ph;
    logic               hint;
    int                 bad_count;
    int                 compares;

    fetch_model fetch (.sys_clk_i(sys_clk), .req_i(req), .byte_i(byte_v),
        .fetch_valid_o(fetch_valid), .opcode_o(opcode));
    mcu_opcode_decoder uut (.sys_clk_i(sys_clk), .rst_i(rst), .fetch_valid_i(fetch_valid),
        .opcode_i(opcode), .decode_o(dec), .decode_valid_o(dec_valid), .read_phase_o(rd_ph),
        .write_phase_o(wr_ph), .shift_left_hint_o(hint));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Leaves the bench two nanoseconds past the edge that follows the taken fetch.
    task automatic issue(input logic [7:0] op);
        @(posedge sys_clk); #1 req = 1'b1; byte_v = op;
        @(posedge sys_clk); #1 req = 1'b0;
        @(posedge sys_clk); #2;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(100 * 1000);
        bad_count++;
        close_out();
    end

    initial begin
        rst = 1'b1; req = 1'b0; byte_v = 8'h00; bad_count = 0; compares = 0;
        repeat (20) @(posedge sys_clk);
        #2 check({dec, dec_valid, rd_ph, wr_ph}, 48'h0);
        #1 rst = 1'b0;
        foreach (rows[i]) begin
            issue(rows[i].op);
            check({dec.valid, dec.kind, dec.mode, dec.length, dec.cycles, dec.rmw, dec_valid},
                  {1'b1, rows[i].k, rows[i].m, rows[i].len, opdec_pkg::CYC_FOUR, rows[i].rmw,
                   1'b1});
            check(rd_ph, rows[i].rmw);
            if (rows[i].ad != 8'h00)
                check({dec.addr_fixed, dec.data_addr}, {1'b1, rows[i].ad});
        end
        $display("test table done");
        @(posedge sys_clk); #1 req = 1'b1; byte_v = 8'hE6;
        @(posedge sys_clk); #1 byte_v = 8'hFE;
        @(posedge sys_clk); #1 req = 1'b0;
        @(posedge sys_clk); #2 check({rd_ph, wr_ph, dec.kind}, {2'b10, UP});
        @(posedge sys_clk); #2 check({rd_ph, wr_ph, dec.mode}, {2'b01, DI});
        @(posedge sys_clk); #2 check({rd_ph, wr_ph, dec_valid}, 3'b000);
        $display("test rmw phases done");
        issue(8'h8C);
        check({dec.kind, dec.mode, dec.target_hi, dec.length, dec.dst, dec.src_a},
              {opdec_pkg::OP_CALL, opdec_pkg::AM_EXTENDED, 4'hC, 2'h2, opdec_pkg::DST_PC,
               opdec_pkg::SRC_NONE});
        issue(8'h93);
        check({dec.kind, dec.target_hi, dec.cycles}, {opdec_pkg::OP_JUMP, 4'h3, 3'h4});
        issue(opdec_pkg::MOVE_IMM);
        check({dec.kind, dec.length, dec.cycles}, {opdec_pkg::OP_MOVE_IMM, 2'h3, 3'h4});
        issue(8'hFA);
        check({hint, dec.kind, dec.mode}, {1'b1, AD, DI});
        @(posedge sys_clk); #2 check(hint, 1'b0);
        issue(8'hFB);
        check({hint, dec.kind}, {1'b0, SB});
        issue(8'hB6);
        check({dec.valid, dec.op_class, dec.length, dec.dst, dec.rmw, rd_ph},
              {1'b0, opdec_pkg::CLS_NONE, 2'h1, opdec_pkg::DST_NONE, 2'b00});
        $display("test special forms done");
        // Mid-run reset must clear a pending read-modify-write sequence.
        issue(8'hE7);
        #1 rst = 1'b1;
        @(posedge sys_clk); #2 check({dec, dec_valid, rd_ph, wr_ph}, 48'h0);
        rst = 1'b0;
        $display("test reset done");
        close_out();
    end
endmodule
